// ===== hdl/bcc_charger.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module bcc_charger (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic [1:0] pwr_state,
  input  wire logic       vin_above_uv,
  input  wire logic [3:0] fused_charge_target_default,
  input  wire logic       fuse_load,
  output logic            charger_on,
  output logic            current_high,
  output logic [3:0]      charge_target_code,
  output logic [8:0]      target_tens_mv
);
  logic [1:0] uv_sync;
  logic       vin_ok;
  logic       vin_ok_d;
  logic       charge_on_active_states;
  logic       charge_on_deep_off;
  logic [3:0] code;

  bcc_sync #(.W(2)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       ({fuse_load, vin_above_uv}),
    .q       (uv_sync)
  );
  assign vin_ok = uv_sync[0];

  function automatic logic [8:0] code_to_mv(input logic [3:0] c);
    logic [8:0] v;
    v = bcc_pkg::mv_base + 9'(({5'h0, c} - 9'h001) * bcc_pkg::mv_step);
    if (c == 4'h0) v = bcc_pkg::mv_code0;
    else if (c == 4'hf) v = bcc_pkg::mv_code15;
    return v;
  endfunction

  wire in_run   = pwr_state == bcc_pkg::bcc_pwr_run;
  wire in_stby  = pwr_state == bcc_pkg::bcc_pwr_stby;
  wire in_off   = pwr_state == bcc_pkg::bcc_pwr_off;
  wire on_state = in_run || in_stby;
  wire uv_cross = vin_ok && !vin_ok_d;
  wire wr_ctrl  = wr_stb && addr == bcc_pkg::ctrl_addr;
  wire wr_code  = wr_stb && addr == bcc_pkg::target_addr;
  wire next_active = uv_cross ? 1'b0 :
                     (wr_ctrl && on_state) ? wdata[bcc_pkg::active_bit] :
                     charge_on_active_states;
  wire next_off    = uv_cross ? 1'b0 :
                     wr_ctrl ? wdata[bcc_pkg::off_bit] : charge_on_deep_off;
  wire [3:0] next_code = (uv_cross || uv_sync[1]) ? fused_charge_target_default :
                         wr_code ? wdata[3:0] : code;
  wire next_chg = (on_state && charge_on_active_states) || (in_off && charge_on_deep_off);
  wire next_cur = (in_run && charge_on_active_states) ? bcc_pkg::cur_high
                                                      : bcc_pkg::cur_low;
  // Read words named apart so each map entry reads on its own
  wire [7:0] rd_ctrl_word   = {6'h0, charge_on_deep_off, charge_on_active_states};
  wire [7:0] rd_code_word   = {4'h0, code};
  wire [7:0] rd_status_word = {4'h0, pwr_state, current_high, charger_on};
  wire [7:0] next_rdata =
    (addr == bcc_pkg::ctrl_addr)   ? rd_ctrl_word :
    (addr == bcc_pkg::target_addr) ? rd_code_word :
    (addr == bcc_pkg::status_addr) ? rd_status_word : 8'h00;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vin_ok_d                <= 1'b0;
      charge_on_active_states <= bcc_pkg::ctrl_rst_val[bcc_pkg::active_bit];
      charge_on_deep_off      <= bcc_pkg::ctrl_rst_val[bcc_pkg::off_bit];
      code                    <= bcc_pkg::code_rst_val;
    end else begin
      vin_ok_d                <= vin_ok;
      charge_on_active_states <= next_active;
      charge_on_deep_off      <= next_off;
      code                    <= next_code;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      charger_on         <= 1'b0;
      current_high       <= bcc_pkg::cur_low;
      charge_target_code <= bcc_pkg::code_rst_val;
      target_tens_mv     <= bcc_pkg::mv_code0;
      rdata              <= 8'h00;
    end else begin
      charger_on         <= next_chg;
      current_high       <= next_chg & next_cur;
      charge_target_code <= code;
      target_tens_mv     <= code_to_mv(code);
      rdata              <= rd_stb ? next_rdata : 8'h00;
    end
  end

  // Named steps, each used by one check
  sequence run_active_s;
    in_run && charge_on_active_states;
  endsequence
  sequence stby_active_s;
    in_stby && charge_on_active_states;
  endsequence
  sequence uv_clear_s;
    uv_cross ##1 (!charge_on_active_states && !charge_on_deep_off);
  endsequence
  sequence ctrl_write_on_s;
    wr_ctrl && on_state && !uv_cross;
  endsequence

  uv_clears_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    uv_cross |=> !charge_on_active_states && !charge_on_deep_off)
    else $error("enable bits not cleared on threshold crossing");
  run_enable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    on_state && charge_on_active_states |=> charger_on)
    else $error("charger not on in run or standby");
  run_disable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    on_state && !charge_on_active_states |=> !charger_on)
    else $error("charger on with active bit clear");
  run_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_run && charge_on_active_states |=> current_high)
    else $error("run state not at high current");
  stby_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_stby |=> !current_high)
    else $error("standby not at low current");
  off_enable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_off |=> charger_on == $past(charge_on_deep_off))
    else $error("deep off enable mismatch");
  off_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_off |=> !current_high)
    else $error("deep off not at low current");
  code_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    code == 4'hf |=> target_tens_mv == 9'h168)
    else $error("top code not 3.6 V");
  fuse_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    uv_cross |=> code == $past(fused_charge_target_default))
    else $error("fused default not loaded");
  wr_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_ctrl && in_off && !uv_cross |=> charge_on_active_states == $past(charge_on_active_states))
    else $error("active bit written outside on states");
  run_seq_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    run_active_s |=> charger_on && current_high)
    else $error("run charging not at high current");
  stby_on_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stby_active_s |=> charger_on && !current_high)
    else $error("standby charging not at low current");
  uv_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    uv_clear_s |=> !charger_on)
    else $error("charger still on after threshold crossing");
  wr_active_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_write_on_s |=> charge_on_active_states == $past(wdata[bcc_pkg::active_bit]))
    else $error("active bit write lost in on state");
  wr_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_ctrl && !uv_cross |=> charge_on_deep_off == $past(wdata[bcc_pkg::off_bit]))
    else $error("off-state bit write lost");
  off_disable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_off && !charge_on_deep_off |=> !charger_on)
    else $error("charger on in deep off with bit clear");
  none_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwr_state == 2'h3 |=> !charger_on && !current_high)
    else $error("charger on in undefined power state");
  cur_gated_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    current_high |-> charger_on)
    else $error("high current selected while charger off");
  code_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    code == 4'h0 |=> target_tens_mv == 9'h0b4)
    else $error("bottom code not 1.8 V");
  code_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    code == 4'h1 |=> target_tens_mv == 9'h0c8)
    else $error("first step code not 2.0 V");
  code_last_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    code == 4'he |=> target_tens_mv == 9'h14a)
    else $error("last step code not 3.3 V");
  fuse_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    uv_sync[1] |=> code == $past(fused_charge_target_default))
    else $error("fused default not reloaded");
  code_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_code && !uv_cross && !uv_sync[1] |=> code == $past(wdata[3:0]))
    else $error("target code write lost");
  code_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> charge_target_code == $past(code))
    else $error("code output does not follow register");
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !rd_stb |=> rdata == 8'h00)
    else $error("read data not zero without strobe");
  rdata_ctrl_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_stb && addr == bcc_pkg::ctrl_addr
    |=> rdata == {6'h00, $past(charge_on_deep_off), $past(charge_on_active_states)})
    else $error("control word readback wrong");
endmodule

// ===== hdl/bcc_pkg.sv
// Function
// - Active enable bit gates charger in run/standby
// - Undervoltage crossing clears both enable bits
// - Run state requests high 60 uA current
// - Standby requests low 10 uA current only
// - Deep off charges only with off-state bit
// - Deep off charging requests low current
// - Four-bit code maps to target voltage
// - Target code default comes from fuses
// - Active enable writable during on states
package bcc_pkg;
  // Register offsets
  localparam logic [3:0] ctrl_addr   = 4'h0;
  localparam logic [3:0] target_addr = 4'h1;
  localparam logic [3:0] status_addr = 4'h2;
  // Control field positions
  localparam int active_bit = 0;
  localparam int off_bit    = 1;
  // Reset values
  localparam logic [1:0] ctrl_rst_val = 2'h0;
  localparam logic [3:0] code_rst_val = 4'h0;
  // Power states on the state input
  typedef enum logic [1:0] {
    bcc_pwr_off  = 2'h0,
    bcc_pwr_run  = 2'h1,
    bcc_pwr_stby = 2'h2
  } bcc_pwr_t;
  // Current select encoding
  localparam logic cur_low  = 1'h0;
  localparam logic cur_high = 1'h1;
  // Target voltage in tens of millivolts
  localparam logic [8:0] mv_code0  = 9'h0b4;
  localparam logic [8:0] mv_base   = 9'h0c8;
  localparam logic [8:0] mv_step   = 9'h00a;
  localparam logic [8:0] mv_code15 = 9'h168;
endpackage

// ===== hdl/bcc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for asynchronous levels
module bcc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== verif/bcc_charger_tb_top.sv
`timescale 1ns/1ps
module bcc_charger_tb_top;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic [1:0] pwr_state = 2'h1;
  logic       vin_above_uv = 1'b0;
  logic [3:0] fused_code = 4'h5;
  logic       fuse_load = 1'b0;
  logic [7:0] rdata;
  logic       charger_on;
  logic       current_high;
  logic [3:0] code;
  logic [8:0] tens_mv;
  logic [7:0] d;
  int         fails = 0;
  int         compares = 0;

  bcc_charger bcc_charger_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pwr_state(pwr_state),
    .vin_above_uv(vin_above_uv), .fused_charge_target_default(fused_code),
    .fuse_load(fuse_load), .charger_on(charger_on), .current_high(current_high),
    .charge_target_code(code), .target_tens_mv(tens_mv));

  initial forever #4 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    tick(3);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pwr(input logic [1:0] s);
    @(posedge ref_clk);
    pwr_state <= s;
    tick(3);
  endtask
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic on, input logic hi);
    compares++;
    if ({charger_on, current_high} !== {on, hi}) begin
      fails++;
      $display("ERROR %0t outputs %b%b expected %b%b", $time, charger_on, current_high, on, hi);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_powerup;
    chk_out(1'b0, 1'b0);
    chk_val(tens_mv, 9'h0b4);
    @(posedge ref_clk);
    vin_above_uv <= 1'b1;
    tick(6);
    chk_val({5'h00, code}, 9'h005);
    chk_val(tens_mv, 9'h0f0);
  endtask
  task automatic t_states;
    wr(bcc_pkg::ctrl_addr, 8'h01);
    chk_out(1'b1, 1'b1);
    rd(bcc_pkg::status_addr);
    chk_val({1'b0, d}, 9'h007);
    pwr(bcc_pkg::bcc_pwr_stby);
    chk_out(1'b1, 1'b0);
    wr(bcc_pkg::ctrl_addr, 8'h00);
    chk_out(1'b0, 1'b0);
    pwr(bcc_pkg::bcc_pwr_run);
    wr(bcc_pkg::ctrl_addr, 8'h02);
    chk_out(1'b0, 1'b0);
    pwr(bcc_pkg::bcc_pwr_off);
    chk_out(1'b1, 1'b0);
    wr(bcc_pkg::ctrl_addr, 8'h01);
    chk_out(1'b0, 1'b0);
    pwr(bcc_pkg::bcc_pwr_run);
    chk_out(1'b0, 1'b0);
    wr(bcc_pkg::ctrl_addr, 8'h03);
    pwr(2'h3);
    chk_out(1'b0, 1'b0);
    pwr(bcc_pkg::bcc_pwr_run);
    chk_out(1'b1, 1'b1);
  endtask
  task automatic t_undervoltage;
    @(posedge ref_clk);
    vin_above_uv <= 1'b0;
    tick(4);
    @(posedge ref_clk);
    vin_above_uv <= 1'b1;
    tick(6);
    chk_out(1'b0, 1'b0);
    rd(bcc_pkg::ctrl_addr);
    chk_val({1'b0, d}, 9'h000);
    rd(4'h3);
    chk_val({1'b0, d}, 9'h000);
  endtask
  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      wr(bcc_pkg::target_addr, 8'(c));
      chk_val(tens_mv, c == 0 ? 9'h0b4 : c == 15 ? 9'h168 : 9'h0be + 9'(c) * 9'h00a);
    end
    @(posedge ref_clk);
    fused_code <= 4'ha;
    fuse_load  <= 1'b1;
    tick(5);
    @(posedge ref_clk);
    fuse_load <= 1'b0;
    chk_val({5'h00, code}, 9'h00a);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(1);
    t_powerup;
    t_states;
    t_undervoltage;
    t_codes;
    stop_test;
  end
  initial begin
    #20000;
    fails++;
    stop_test;
  end
endmodule
